//--- hw/rt_init_map.vh
/*
 Constants for the remote terminal reset and EEPROM auto-init controller.
 Assumes inclusion by the controller and its bench; definitions only.
*/
`ifndef RT_INIT_MAP_VH
`define RT_INIT_MAP_VH
// AHB byte offsets of the controller's own registers
`define A_CTRL        8'h00
`define A_STATUS      8'h04
`define A_BITWORD     8'h08
`define A_FAILADDR    8'h0c
`define A_CHKSUM      8'h10
`define A_DESCBASE    8'h14
`define A_CFG2        8'h18
`define A_MEMADDR     8'h1c
`define A_MEMDATA     8'h20
// Control register fields
`define C_START_EXECUTION_BIT        0
`define C_SOFT_RESET_BIT        1
// Status register fields
`define S_EEPROM_CHECKSUM_FAIL       0
`define S_READBACK_MISMATCH_FLAG       1
`define S_ADDRESS_PARITY_FAIL       2
`define S_LOCK        3
`define S_AUTO_INIT_ENABLE      4
`define S_RT_ADDR_PARITY_PIN        9
// Bit word fields
`define B_EEPROM_LOAD_FAIL_FLAG        1
`define B_APF         2
`define B_SHUT_A      14
`define B_SHUT_B      15
`define B_TFINH       0
// Device word addresses
`define W_CFG1        15'h0000
`define W_STATUS      15'h0002
`define W_PEND        15'h0006
`define W_TTAG        15'h0008
`define W_BIT         15'h0014
`define W_CHK         15'h0020
`define W_DESC        15'h0200
`define W_LAST_FULL   15'h7fff
`define W_LAST_SMALL  15'h03ff
`define DESC_RESET    16'h0200
`define DESC_WORDS    8'd128
// Control word bits cleared by soft reset (accessed, ping-pong, busy, broadcast_buffer_flag)
`define CW_CLR_MASK   16'h000f
// EEPROM serial link
`define EE_READ_CMD   8'h03
`define SCK_HALF      4'd6
`endif

//--- hw/rt_reset_autoinit_control.v
/*
 Reset, EEPROM auto-initialization and soft reset control of a remote terminal.
 Assumes one 100 MHz clock, synchronous active-high reset standing for master
 reset, a single AHB-Lite master, an SPI EEPROM on the dedicated port and a
 32K x 16 internal memory declared here.
*/
// Our own choices: the AHB-Lite register port and the placing of the registers.
// Contract
// RQ1 - Latched auto-init loads registers and RAM from EEPROM; ready held low meanwhile
// RQ2 - Range pin low loads to 0x7FFF, high loads only lower 1K
// RQ3 - Every written word read back and compared; mismatch recorded as error (only RAM words here; 0x0000, 0x0002, 0x0020 not compared)
// RQ4 - Checksum counts stored word at 0x0020, skips 0x0002, 0x0006, 0x0008, 0x0014
// RQ5 - Words summed with stored checksum; zero total means success, else failure
// RQ6 - Byte pairs read in sequence, merged to words, stored and summed
// RQ7 - Big-endian: word N upper byte from 2N, lower byte from 2N+1
// RQ8 - At load end stored checksum goes to 0x0020, then ready rises
// RQ9 - On error after ready: hardware interrupt, status fail flag, load-fail flag
// RQ10 - Only the first mismatching address is logged
// RQ11 - Start bit set only if image bit high and all error flags clear
// RQ12 - Host may override load errors but not an address parity error
// RQ13 - Image start bit low: wait for host write after ready
// RQ14 - Master reset latches enable, lock, address pins; image overwrites only unlocked
// RQ15 - Soft reset by host write or reset mode command with option set
// RQ16 - Soft reset negates ready, active, interrupts; keeps error and broadcast flags
// RQ17 - Soft reset sets descriptor base 0x0200, clears status bits, time tag, tests
// RQ18 - Soft reset clears bit word except parity flag; lifts shutdown and inhibit
// RQ19 - Soft reset clears four flag bits in all 128 primary control words
// RQ20 - After soft reset ready rises; operation resumes only if start bit was set
// RQ21 - Reset mode command clears flags, bit word bits 0/14/15, shutdown, inhibit
// RQ22 - Host completes reset-mode-command reset within 5 ms
// RQ23 - EEPROM serial clock about 8.3 MHz
// RQ24 - EEPROM read with standard read command from address zero ascending
`timescale 1ns/100ps
`default_nettype none
`include "rt_init_map.vh"
module rt_reset_autoinit_control (
   input  wire        i_clock,
   input  wire        i_rst,
   input  wire        i_auto_init_enable,
   input  wire        i_lock,
   input  wire        i_eeprom_small_range_sel,
   input  wire [4:0]  i_rt_addr_pins,
   input  wire        i_rt_addr_parity_pin,
   input  wire        i_reset_terminal_modecode,
   input  wire        i_bus_active,
   input  wire        i_ee_miso,
   input  wire [31:0] i_haddr,
   input  wire [1:0]  i_htrans,
   input  wire        i_hwrite,
   input  wire [2:0]  i_hsize,
   input  wire [31:0] i_hwdata,
   input  wire        i_hsel,
   input  wire        i_hready,
   output reg  [31:0] o_hrdata,
   output reg         o_hreadyout,
   output reg         o_hresp,
   output reg         o_ee_sck,
   output reg         o_ee_cs_n,
   output reg         o_ee_mosi,
   output reg         o_ready,
   output reg         o_active,
   output reg         o_hw_interrupt_n,
   output reg         o_msg_interrupt_n,
   output reg         o_run
);
   localparam ST_IDLE = 4'd0, ST_CMD = 4'd1, ST_RD = 4'd2, ST_WR = 4'd3, ST_CHK = 4'd4;
   localparam ST_END = 4'd5, ST_DONE = 4'd6, ST_SR = 4'd7, ST_SRW = 4'd8;

   reg [15:0] mem [0:32767];
   reg [3:0]  state;
   reg [15:0] ctrl, status, bitword, failaddr, chksum, descbase, cfg2;
   reg [15:0] stwbits, ttag, test0, test1, test2, test3;
   reg        msg_error_flag, broadcast_received_flag, tx_shutdown, tf_inhibit;
   reg        locked, small_range, ld_err_mis, image_start_execution_bit, first_mis;
   reg [14:0] waddr, memaddr;
   reg [15:0] tally, word;
   reg [39:0] shreg;
   reg [5:0]  bitcnt;
   reg [3:0]  sckdiv;
   reg [1:0]  miso_s, mc_s, act_s;
   reg [8:0]  strap_m, strap_s;
   reg        mc_d;
   reg [7:0]  cwcnt;
   reg        dph_act, dph_wr;
   reg [7:0]  dph_addr;

   // Parity check of terminal address (odd parity across address and bit)
   function parity_ok;
      input [5:0] v;
      begin
         parity_ok = ^v;
      end
   endfunction

   function skip_word;
      input [14:0] a;
      begin
         skip_word = (a == `W_STATUS) || (a == `W_PEND) || (a == `W_TTAG) ||
                     (a == `W_BIT); // RQ4
      end
   endfunction

   wire       sck_tick = (sckdiv == `SCK_HALF - 4'd1);
   wire [14:0] last_w = small_range ? `W_LAST_SMALL : `W_LAST_FULL; // RQ2
   wire       mc_rise = mc_s[1] & ~mc_d;
   wire       wr_go = dph_act & dph_wr;
   wire       soft_reset_bit_req = (wr_go && dph_addr == `A_CTRL && i_hwdata[`C_SOFT_RESET_BIT]) ||
                         (mc_rise && cfg2[0]); // RQ15
   wire       apf_now = ~parity_ok(status[15:10]);

   always @(posedge i_clock) begin
      miso_s <= {miso_s[0], i_ee_miso};
      mc_s   <= {mc_s[0], i_reset_terminal_modecode};
      act_s  <= {act_s[0], i_bus_active};
      mc_d   <= mc_s[1];
      // Straps are pins too: two stages before the latch reads them
      strap_m <= {i_auto_init_enable, i_lock, i_eeprom_small_range_sel, i_rt_addr_pins,
                  i_rt_addr_parity_pin};
      strap_s <= strap_m;
   end

   // AHB data phase tracking; zero wait states, always OKAY
   always @(posedge i_clock) begin
      if (i_rst) begin
         dph_act     <= 1'b0;
         dph_wr      <= 1'b0;
         dph_addr    <= 8'h00;
         o_hreadyout <= 1'b1;
         o_hresp     <= 1'b0;
         o_hrdata    <= 32'h00000000;
      end else begin
         o_hresp <= 1'b0;
         o_hreadyout <= 1'b1;
         if (i_hready) begin
            dph_act  <= i_hsel & i_htrans[1];
            dph_wr   <= i_hwrite;
            dph_addr <= i_haddr[7:0];
            if (i_hsel & i_htrans[1] & ~i_hwrite) begin
               case (i_haddr[7:0])
                  `A_CTRL:     o_hrdata <= {16'h0000, ctrl};
                  `A_STATUS:   o_hrdata <= {16'h0000, status};
                  `A_BITWORD:  o_hrdata <= {16'h0000, bitword};
                  `A_FAILADDR: o_hrdata <= {16'h0000, failaddr};
                  `A_CHKSUM:   o_hrdata <= {16'h0000, chksum};
                  `A_DESCBASE: o_hrdata <= {16'h0000, descbase};
                  `A_CFG2:     o_hrdata <= {16'h0000, cfg2};
                  `A_MEMADDR:  o_hrdata <= {17'h00000, memaddr};
                  `A_MEMDATA:  o_hrdata <= {16'h0000, mem[memaddr]};
                  default:     o_hrdata <= 32'h00000000;
               endcase
            end
         end
      end
   end

   always @(posedge i_clock) begin
      if (i_rst) begin
         state <= ST_IDLE;
         ctrl <= 16'h0000;
         status <= 16'h0000;
         bitword <= 16'h0000;
         failaddr <= 16'h0000;
         chksum <= 16'h0000;
         descbase <= `DESC_RESET;
         cfg2 <= 16'h0000;
         stwbits <= 16'h0000;
         ttag <= 16'h0000;
         test0 <= 16'h0000;
         test1 <= 16'h0000;
         test2 <= 16'h0000;
         test3 <= 16'h0000;
         msg_error_flag <= 1'b0;
         broadcast_received_flag <= 1'b0;
         tx_shutdown <= 1'b0;
         tf_inhibit <= 1'b0;
         locked <= 1'b0;
         small_range <= 1'b0;
         ld_err_mis <= 1'b0;
         image_start_execution_bit <= 1'b0;
         first_mis <= 1'b1;
         waddr <= 15'h0000;
         memaddr <= 15'h0000;
         tally <= 16'h0000;
         word <= 16'h0000;
         shreg <= 40'h0000000000;
         bitcnt <= 6'd0;
         sckdiv <= 4'd0;
         cwcnt <= 8'd0;
         o_ee_sck <= 1'b1;
         o_ee_cs_n <= 1'b1;
         o_ee_mosi <= 1'b0;
         o_ready <= 1'b0;
         o_active <= 1'b0;
         o_run <= 1'b0;
         o_hw_interrupt_n <= 1'b1;
         o_msg_interrupt_n <= 1'b1;
      end else begin
         o_active <= act_s[1] & o_run;
         sckdiv <= sck_tick ? 4'd0 : sckdiv + 4'd1; // RQ23
         if (mc_rise) begin
            msg_error_flag <= 1'b0; // RQ21
            broadcast_received_flag <= 1'b0;
            bitword[`B_TFINH] <= 1'b0;
            bitword[`B_SHUT_A] <= 1'b0;
            bitword[`B_SHUT_B] <= 1'b0;
            tx_shutdown <= 1'b0;
            tf_inhibit <= 1'b0;
         end
         case (state)
            ST_IDLE: begin
               // Pins latched one clock after release, as sampled two clocks earlier
               status <= {strap_s[5:1], strap_s[0], 4'h0,
                          1'b0, strap_s[8], strap_s[7], 3'b000}; // RQ14
               locked <= strap_s[7];
               small_range <= strap_s[6];
               if (strap_s[8]) begin
                  state <= ST_CMD; // RQ1
                  o_ee_cs_n <= 1'b0;
                  shreg <= {`EE_READ_CMD, 16'h0000, 16'h0000}; // RQ24
                  bitcnt <= 6'd24;
                  waddr <= 15'h0000;
                  tally <= 16'h0000;
               end else begin
                  // No load: still pass the end step so ready rises
                  state <= ST_END;
               end
            end
            ST_CMD: if (sck_tick) begin
               o_ee_sck <= ~o_ee_sck;
               if (o_ee_sck) begin
                  o_ee_mosi <= shreg[39];
                  shreg <= {shreg[38:0], 1'b0};
               end else begin
                  bitcnt <= bitcnt - 6'd1;
                  if (bitcnt == 6'd1) begin
                     state <= ST_RD;
                     bitcnt <= 6'd16;
                  end
               end
            end
            ST_RD: if (sck_tick) begin
               o_ee_sck <= ~o_ee_sck;
               if (!o_ee_sck) begin
                  word <= {word[14:0], miso_s[1]}; // RQ6 RQ7
                  bitcnt <= bitcnt - 6'd1;
                  if (bitcnt == 6'd1)
                     state <= ST_WR;
               end
            end
            ST_WR: begin
               if (waddr == `W_CHK) begin
                  chksum <= word;
               end else if (waddr == `W_STATUS) begin
                  if (!locked)
                     status[15:9] <= word[15:9]; // RQ14
               end else if (waddr == `W_CFG1) begin
                  image_start_execution_bit <= word[`C_START_EXECUTION_BIT];
               end else begin
                  mem[waddr] <= word;
               end
               if (!skip_word(waddr))
                  tally <= tally + word; // RQ4 RQ5
               state <= ST_CHK;
            end
            ST_CHK: begin
               if (waddr != `W_CHK && waddr != `W_STATUS && waddr != `W_CFG1 &&
                   mem[waddr] != word) begin
                  ld_err_mis <= 1'b1; // RQ3
                  if (first_mis) begin
                     failaddr <= {1'b0, waddr}; // RQ10
                     first_mis <= 1'b0;
                  end
               end
               if (waddr == last_w) begin
                  state <= ST_END;
                  o_ee_cs_n <= 1'b1;
                  o_ee_sck <= 1'b1;
               end else begin
                  waddr <= waddr + 15'h0001;
                  bitcnt <= 6'd16;
                  state <= ST_RD;
               end
            end
            ST_END: begin
               mem[`W_CHK] <= chksum; // RQ8
               o_ready <= 1'b1;
               status[`S_EEPROM_CHECKSUM_FAIL] <= (tally != 16'h0000); // RQ5 RQ9
               status[`S_READBACK_MISMATCH_FLAG] <= ld_err_mis;
               status[`S_ADDRESS_PARITY_FAIL] <= apf_now;
               bitword[`B_APF] <= apf_now;
               if (tally != 16'h0000 || ld_err_mis) begin
                  o_hw_interrupt_n <= 1'b0; // RQ9
                  bitword[`B_EEPROM_LOAD_FAIL_FLAG] <= 1'b1;
               end
               if (image_start_execution_bit && tally == 16'h0000 && !ld_err_mis && !apf_now)
                  ctrl[`C_START_EXECUTION_BIT] <= 1'b1; // RQ11
               state <= ST_DONE;
            end
            ST_DONE: begin
               o_run <= ctrl[`C_START_EXECUTION_BIT];
               status[`S_ADDRESS_PARITY_FAIL] <= apf_now;
               if (soft_reset_bit_req) begin
                  o_ready <= 1'b0; // RQ16
                  o_run <= 1'b0;
                  o_active <= 1'b0;
                  o_hw_interrupt_n <= 1'b1;
                  o_msg_interrupt_n <= 1'b1;
                  ctrl[`C_SOFT_RESET_BIT] <= 1'b1;
                  state <= ST_SR;
               end else if (wr_go) begin
                  case (dph_addr)
                     `A_CTRL: ctrl[`C_START_EXECUTION_BIT] <= i_hwdata[`C_START_EXECUTION_BIT] & ~apf_now; // RQ12 RQ13
                     `A_STATUS: status[15:9] <= i_hwdata[15:9];
                     `A_CFG2: cfg2 <= i_hwdata[15:0];
                     `A_MEMADDR: memaddr <= i_hwdata[14:0];
                     `A_MEMDATA: mem[memaddr] <= i_hwdata[15:0];
                     default: ;
                  endcase
               end
            end
            ST_SR: begin
               descbase <= `DESC_RESET; // RQ17
               stwbits <= 16'h0000;
               ttag <= 16'h0000;
               test0 <= 16'h0000;
               test1 <= 16'h0000;
               test2 <= 16'h0000;
               test3 <= 16'h0000;
               bitword <= bitword & (16'h0001 << `B_APF); // RQ18
               tx_shutdown <= 1'b0;
               tf_inhibit <= 1'b0;
               cwcnt <= 8'd0;
               state <= ST_SRW;
            end
            ST_SRW: begin
               mem[`W_DESC + {5'h00, cwcnt, 2'b00}] <=
                  mem[`W_DESC + {5'h00, cwcnt, 2'b00}] & ~`CW_CLR_MASK; // RQ19
               cwcnt <= cwcnt + 8'd1;
               if (cwcnt == `DESC_WORDS - 8'd1) begin
                  ctrl[`C_SOFT_RESET_BIT] <= 1'b0;
                  o_ready <= 1'b1; // RQ20
                  state <= ST_DONE;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

//--- tb/ee_model.sv
/* Serial EEPROM model holding a 1K word image, checksum word optionally off by one.
   Assumes SPI mode 3, a read command and address before the data. */
`timescale 1ns/100ps
`default_nettype none
module ee_model #(parameter logic BAD = 1'b1) (
   input  wire logic i_sck,
   input  wire logic i_cs_n,
   input  wire logic i_mosi,
   output var  logic o_miso,
   output var  logic o_cmd_ok
);
   logic [15:0] img [0:1023];
   logic [15:0] sum;
   logic [23:0] hdr;
   int          cnt;
   initial begin
      o_miso = 1'b0;
      o_cmd_ok = 1'b0;
      sum = 16'h0000;
      for (int k = 0; k < 1024; k++) begin
         img[k] = (k == 0) ? 16'h0001 : (k < 33) ? 16'h0000 : 16'(k) ^ 16'hc3a5;
         if (k != 2 && k != 6 && k != 8 && k != 20 && k != 32)
            sum = sum + img[k];
      end
      img[32] = 16'h0000 - sum + {15'h0, BAD};
   end
   always @(negedge i_cs_n)
      cnt = 0;
   always @(posedge i_sck) begin
      if (cnt < 24)
         hdr = {hdr[22:0], i_mosi};
      cnt = cnt + 1;
      if (cnt == 24)
         o_cmd_ok = (hdr == 24'h030000);
   end
   // Data changes on the falling edge so the rising edge samples it settled
   always @(negedge i_sck)
      if (!i_cs_n && cnt >= 24)
         o_miso <= img[((cnt - 24) / 16) % 1024][15 - (cnt - 24) % 16];
   // Released line must not keep the last bit
   always @(posedge i_cs_n)
      o_miso <= ~o_miso;
endmodule
`default_nettype wire

//--- tb/rt_init_chk.sv
/* Pin assertions for the reset and auto-init controller.
   Assumes one clock domain; bound to the controller at the foot. */
`timescale 1ns/100ps
`default_nettype none
module rt_init_chk (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic o_ee_sck,
   input wire logic o_ee_cs_n,
   input wire logic o_ready,
   input wire logic o_active,
   input wire logic o_hw_interrupt_n,
   input wire logic o_msg_interrupt_n,
   input wire logic o_run
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_rst);
   logic [7:0] since_rst;
   always_ff @(posedge i_clock)
      if (i_rst)
         since_rst <= 8'h00;
      else if (since_rst != 8'hff)
         since_rst <= since_rst + 8'h01;
   property p_ready_low; !o_ee_cs_n |-> !o_ready; endproperty
   a_ready_low: assert property (p_ready_low) else $error("ready high during load");
   property p_sck_half; $fell(o_ee_sck) |-> (!o_ee_sck)[*6] ##1 o_ee_sck; endproperty
   a_sck_half: assert property (p_sck_half) else $error("serial clock half period");
   property p_sck_idle; o_ee_cs_n |-> o_ee_sck; endproperty
   a_sck_idle: assert property (p_sck_idle) else $error("serial clock not idle");
   property p_one_load; $fell(o_ee_cs_n) |-> since_rst < 8'h10; endproperty
   a_one_load: assert property (p_one_load) else $error("load not after reset");
   property p_int_ready; !o_hw_interrupt_n |-> o_ready; endproperty
   a_int_ready: assert property (p_int_ready) else $error("interrupt without ready");
   property p_run_ready; o_run |-> o_ready; endproperty
   a_run_ready: assert property (p_run_ready) else $error("run without ready");
   property p_active_run; o_active |-> o_run; endproperty
   a_active_run: assert property (p_active_run) else $error("active while stopped");
   property p_msg_int; o_msg_interrupt_n; endproperty
   a_msg_int: assert property (p_msg_int) else $error("message interrupt low");
   property p_mr_out;
      disable iff (1'b0) i_rst |=> !o_ready && o_ee_cs_n && o_hw_interrupt_n && !o_run;
   endproperty
   a_mr_out: assert property (p_mr_out) else $error("outputs not reset");
endmodule
bind rt_reset_autoinit_control rt_init_chk rt_init_chk_i (
   .i_clock(i_clock), .i_rst(i_rst), .o_ee_sck(o_ee_sck), .o_ee_cs_n(o_ee_cs_n),
   .o_ready(o_ready), .o_active(o_active), .o_hw_interrupt_n(o_hw_interrupt_n),
   .o_msg_interrupt_n(o_msg_interrupt_n), .o_run(o_run));
`default_nettype wire

//--- tb/tb_rt_reset_autoinit_control.sv
/* Bench for the reset and auto-init controller: AHB tasks and ordered tests.
   Assumes the EEPROM model and checker compile first; one small-range load. */
`timescale 1ns/100ps
`default_nettype none
`include "rt_init_map.vh"
module tb_rt_reset_autoinit_control;
   logic        i_clock = 1'b0;
   logic        i_rst = 1'b1;
   logic        auto_init_enable = 1'b1;
   logic        par = 1'b0;
   logic        mc = 1'b0;
   logic        bus_act = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic        hsel = 1'b0;
   logic [31:0] rd;
   wire  [31:0] hrdata;
   wire         hready, hresp, sck, cs_n, mosi, miso, cmd_ok;
   wire         ready, active, hw_int_n, msg_int_n, run;
   int          n_fail = 0;
   int          check_count = 0;
   int          n_sck = 0;
   always #5 i_clock = ~i_clock;
   // Serial clock rises while selected: command plus the loaded range
   always @(posedge sck)
      if (cs_n === 1'b0)
         n_sck++;
   rt_reset_autoinit_control rt_reset_autoinit_control_i (
      .i_clock(i_clock), .i_rst(i_rst), .i_auto_init_enable(auto_init_enable), .i_lock(1'b1),
      .i_eeprom_small_range_sel(1'b1), .i_rt_addr_pins(5'h01), .i_rt_addr_parity_pin(par),
      .i_reset_terminal_modecode(mc), .i_bus_active(bus_act), .i_ee_miso(miso),
      .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
      .i_hwdata(hwdata), .i_hsel(hsel), .i_hready(hready), .o_hrdata(hrdata),
      .o_hreadyout(hready), .o_hresp(hresp), .o_ee_sck(sck), .o_ee_cs_n(cs_n),
      .o_ee_mosi(mosi), .o_ready(ready), .o_active(active), .o_hw_interrupt_n(hw_int_n),
      .o_msg_interrupt_n(msg_int_n), .o_run(run));
   ee_model ee_model_i (.i_sck(sck), .i_cs_n(cs_n), .i_mosi(mosi), .o_miso(miso),
      .o_cmd_ok(cmd_ok));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_pin(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clock);
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      hsel <= 1'b1;
      do @(posedge i_clock); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge i_clock); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      ahb(1'b1, a, d);
   endtask
   task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
      ahb(1'b0, a, 32'h0);
      chk(rd & m, exp);
   endtask
   task automatic mem(input logic [31:0] w, input logic [31:0] exp);
      wr(`A_MEMADDR, w);
      rdm(`A_MEMDATA, 32'hffffffff, exp);
   endtask
   task automatic wait_ready(input logic lvl);
      for (int k = 0; k < 250000 && ready !== lvl; k++)
         @(posedge i_clock);
      chk_pin(ready, lvl);
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Small range load alone is about 200k cycles
   initial begin
      repeat (400000) @(posedge i_clock);
      n_fail++;
      results;
   end
   initial begin
      repeat (4) @(posedge i_clock);
      i_rst <= 1'b0;
      repeat (20) @(posedge i_clock);
      chk_pin(ready, 1'b0);
      chk_pin(cs_n, 1'b0);
      wait_ready(1'b1);
      repeat (3) @(posedge i_clock);
      chk_pin(cmd_ok, 1'b1);
      chk_pin(hw_int_n, 1'b0);
      chk_pin(run, 1'b0);
      rdm(`A_STATUS, 32'h1f, 32'h19);
      rdm(`A_BITWORD, 32'h2, 32'h2);
      rdm(`A_CHKSUM, 32'hffffffff, {16'h0, ee_model_i.img[32]});
      mem(32'h0020, {16'h0, ee_model_i.img[32]});
      rdm(`A_FAILADDR, 32'hffffffff, 32'h0);
      mem(32'h0300, 32'h0300 ^ 32'hc3a5);
      mem(32'h03ff, 32'h03ff ^ 32'hc3a5);
      chk(n_sck, 32'h18 + 32'h10 * 32'h400);
      wr(`A_CTRL, 32'h1);
      bus_act <= 1'b1;
      repeat (6) @(posedge i_clock);
      chk_pin(run, 1'b1);
      chk_pin(active, 1'b1);
      wr(`A_CTRL, 32'h3);
      wait_ready(1'b0);
      chk_pin(active, 1'b0);
      wait_ready(1'b1);
      repeat (6) @(posedge i_clock);
      chk_pin(run, 1'b1);
      chk_pin(hw_int_n, 1'b1);
      rdm(`A_DESCBASE, 32'hffffffff, 32'h0200);
      rdm(`A_BITWORD, 32'hffffffff, 32'h0);
      for (logic [31:0] w = 32'h200; w < 32'h400; w += 32'h1fc)
         mem(w, (w ^ 32'hc3a5) & 32'hfff0);
      mem(32'h0201, 32'hc1a4);
      // Mode command with the option clear must not reset
      mc <= 1'b1;
      repeat (4) @(posedge i_clock);
      mc <= 1'b0;
      repeat (6) @(posedge i_clock);
      chk_pin(ready, 1'b1);
      wr(`A_CFG2, 32'h1);
      mc <= 1'b1;
      repeat (4) @(posedge i_clock);
      mc <= 1'b0;
      wait_ready(1'b0);
      wait_ready(1'b1);
      chk_pin(cs_n, 1'b1);
      // Even parity straps, no auto-init
      i_rst <= 1'b1;
      auto_init_enable <= 1'b0;
      par <= 1'b1;
      repeat (4) @(posedge i_clock);
      i_rst <= 1'b0;
      wait_ready(1'b1);
      wr(`A_CTRL, 32'h1);
      repeat (4) @(posedge i_clock);
      chk_pin(run, 1'b0);
      rdm(`A_STATUS, 32'h1c, 32'h0c);
      wr(`A_STATUS, 32'h0400);
      wr(`A_CTRL, 32'h1);
      repeat (4) @(posedge i_clock);
      chk_pin(run, 1'b1);
      results;
   end
endmodule
`default_nettype wire
